// File: casp_fifo.sv
// Small character FIFO with registered read data.
// Assumes one clock, asynchronous active-low reset; writes while full and reads while empty are ignored.
`timescale 1ns/1ps
module casp_fifo
	import casp_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_sys_in,
	input  wire logic         arst_n_in,
	// Write side
	input  wire logic         wr_in,
	input  wire casp_rxchar_s wdata_in,
	// Read side
	input  wire logic         rd_in,
	output casp_rxchar_s      rdata_out,
	output logic              empty_out,
	output logic              full_out
);
	typedef struct packed {
		logic [CASP_FIFO_AW:0] wp;
		logic [CASP_FIFO_AW:0] rp;
		casp_rxchar_s          rd;
	} casp_fst_s;
	casp_fst_s    st_q, st_d;
	casp_rxchar_s mem_q [0:(1<<CASP_FIFO_AW)-1];
	logic [CASP_FIFO_AW:0] lvl;
	// Level and flags
	assign lvl       = st_q.wp - st_q.rp;
	assign empty_out = (lvl == '0);
	assign full_out  = (lvl == CASP_FIFO_DEPTH);
	assign rdata_out = st_q.rd;
	// Pointer update; read data follows the head entry
	always_comb begin
		st_d = st_q;
		if (wr_in && !full_out) begin
			st_d.wp = st_q.wp + 1'b1;
		end
		if (rd_in && !empty_out) begin
			st_d.rp = st_q.rp + 1'b1;
		end
		st_d.rd = mem_q[st_d.rp[CASP_FIFO_AW-1:0]];
		if (st_d.rp == st_q.wp && wr_in && !full_out) begin
			st_d.rd = wdata_in;
		end
	end
	// State register
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	// Storage
	always_ff @(posedge clk_sys_in) begin
		if (wr_in && !full_out) begin
			mem_q[st_q.wp[CASP_FIFO_AW-1:0]] <= wdata_in;
		end
	end
endmodule

// File: casp_peer.sv
// Remote serial node: sends frames on the receive line and decodes frames from the transmit line.
// Assumes the bench sets bit_len to the port's bit time in clocks.
`timescale 1ns/1ps
module casp_peer (
	// Clock
	input  wire logic clk_sys_in,
	// Serial lines
	input  wire logic tx_in,
	output logic      rx_out,
	output logic      cts_n_out
);
	int unsigned bit_len = 16;
	// Idle line high, ready to accept
	initial begin
		rx_out = 1'b1;
		cts_n_out = 1'b0;
	end
	// Clear-to-send level, low when this node can accept
	task automatic set_cts(input logic v);
		@(posedge clk_sys_in);
		cts_n_out <= v;
	endtask
	// Start low, bits LSB first, one stop of the given level, back to idle
	// The line only changes on system clock edges, so it arrives in this clock domain
	task automatic send(input logic [9:0] d, input int n, input logic stop);
		rx_out <= 1'b0;
		repeat (bit_len) @(posedge clk_sys_in);
		for (int i = 0; i < n; i++) begin
			rx_out <= d[i];
			repeat (bit_len) @(posedge clk_sys_in);
		end
		rx_out <= stop;
		repeat (bit_len) @(posedge clk_sys_in);
		rx_out <= 1'b1;
		repeat (bit_len) @(posedge clk_sys_in);
	endtask
	// Wait for a start edge, sample n bits at mid-bit, then check the stop bits
	task automatic get(input int n, input int nstop, output logic [9:0] d, output bit ok);
		int t = 0;
		d = '0;
		while (tx_in !== 1'b0 && t < 20000) begin
			@(posedge clk_sys_in);
			t++;
		end
		ok = (t < 20000);
		repeat (bit_len / 2) @(posedge clk_sys_in);
		for (int i = 0; i < n; i++) begin
			repeat (bit_len) @(posedge clk_sys_in);
			d[i] = tx_in;
		end
		for (int i = 0; i < nstop; i++) begin
			repeat (bit_len) @(posedge clk_sys_in);
			ok &= (tx_in === 1'b1);
		end
	endtask
endmodule

// File: casp_pkg.sv
// Package for the configurable asynchronous serial port: register map, fields, resets, types.
// Assumes a single 200 MHz system clock and an AXI4-Lite master with 32-bit data.
package casp_pkg;
	// Register byte offsets
	localparam logic [7:0] CASP_CTRL_OFS     = 8'h00;
	localparam logic [7:0] CASP_STATUS_OFS   = 8'h04;
	localparam logic [7:0] CASP_TXDATA_OFS   = 8'h08;
	localparam logic [7:0] CASP_RXDATA_OFS   = 8'h0C;
	localparam logic [7:0] CASP_IRQEN_OFS    = 8'h10;
	localparam logic [7:0] CASP_ADDR_OFS     = 8'h14;
	localparam logic [7:0] CASP_DIV_OFS      = 8'h18;
	// Control field positions
	localparam int CASP_CTRL_DBITS_LSB  = 0;
	localparam int CASP_CTRL_PAR_LSB    = 4;
	localparam int CASP_CTRL_STOP2_BIT  = 6;
	localparam int CASP_CTRL_OS8_BIT    = 7;
	localparam int CASP_CTRL_VOTE_BIT   = 8;
	localparam int CASP_CTRL_FLOW_BIT   = 9;
	localparam int CASP_CTRL_BREAK_BIT  = 10;
	localparam int CASP_CTRL_ADMODE_BIT = 11;
	localparam int CASP_CTRL_TXON_BIT   = 12;
	localparam int CASP_CTRL_RXON_BIT   = 13;
	localparam int CASP_CTRL_MARK_BIT   = 14;
	// Reset values: 8 data bits, no parity, one stop bit, 16x, both directions on
	localparam logic [31:0] CASP_CTRL_RST  = 32'h0000_3008;
	localparam logic [31:0] CASP_IRQEN_RST = 32'h0000_0000;
	localparam logic [15:0] CASP_DIV_RST   = 16'h0001;
	localparam logic [15:0] CASP_ADDR_RST  = 16'h0000;
	// Break length in bit times
	localparam logic [4:0]  CASP_BREAK_BITS = 5'h0D;
	// FIFO depth
	localparam int CASP_FIFO_AW = 2;
	localparam logic [CASP_FIFO_AW:0] CASP_FIFO_DEPTH = 3'h4;
	// Parity selections
	typedef enum logic [1:0] {
		CASP_PAR_NONE = 2'b00,
		CASP_PAR_ODD  = 2'b01,
		CASP_PAR_EVEN = 2'b10,
		CASP_PAR_MS   = 2'b11
	} casp_par_e;
	// Serial engine states
	typedef enum logic [2:0] {
		CASP_IDLE   = 3'b000,
		CASP_START  = 3'b001,
		CASP_DATA   = 3'b010,
		CASP_PARITY = 3'b011,
		CASP_STOP   = 3'b100,
		CASP_BREAK  = 3'b101
	} casp_state_e;
	// Received character with flags
	typedef struct packed {
		logic       brk;
		logic       frame_err;
		logic       par_err;
		logic       ninth;
		logic [8:0] data;
	} casp_rxchar_s;
endpackage

// File: casp_uart.sv
// Configurable asynchronous serial port with AXI4-Lite registers.
// Assumes rx and cts_n come from pins; the port adds its own two-flop synchronisers.
`timescale 1ns/1ps
module casp_uart
	import casp_pkg::*;
#(
	parameter bit HAS_TX = 1'b1,
	parameter bit HAS_RX = 1'b1
)(
	// Clock and resets
	input  wire logic        clk_sys_in,
	input  wire logic        arst_n_in,
	input  wire logic        srst_in,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial pins
	input  wire logic        rx_in,
	input  wire logic        cts_n_in,
	output logic             tx_out,
	output logic             rts_n_out,
	output logic             tx_en_out,
	// Interrupts and CRC feed
	output logic             tx_irq_out,
	output logic             rx_irq_out,
	output logic             tx_crc_data_out,
	output logic             tx_crc_clk_out,
	output logic             rx_crc_data_out,
	output logic             rx_crc_clk_out
);
	typedef struct packed {
		logic [1:0]  rx_sy, cts_sy;
		logic        aw_h, w_h, bv, rv;
		logic [7:0]  aw_a;
		logic [31:0] w_d, rdat;
		logic [31:0] ctrl, irqen;
		logic [15:0] div, addr;
		logic [15:0] pre;
		logic        tick;
		logic [3:0]  rx_os, tx_os;
		casp_state_e rx_st, tx_st;
		logic [3:0]  rx_n, tx_n;
		logic [8:0]  rx_sh, tx_sh;
		logic        rx_par, tx_par, rx_ninth, rx_zero, prev_rx;
		logic [2:0]  vote;
		logic        th_v;
		logic [8:0]  th_d;
		logic        tx_done, ovr, adm, mrk, brk_req;
		logic        txc_d, txc_c, rxc_d, rxc_c;
		logic [4:0]  brk_n;
	} casp_st_s;
	casp_st_s     q, d;
	casp_rxchar_s fifo_w, fifo_r;
	logic fifo_wr, fifo_rd, fifo_empty, fifo_full;
	logic rx_s, cts_s, tick_os, mid_os, last_os, rx_bit;
	logic [3:0] dbits, os_max;
	casp_par_e par;
	logic [6:0] rx_sts;
	logic [3:0] tx_sts;

	// Whether the first n bits hold an odd number of ones, for parity
	function automatic logic odd_ones(input logic [8:0] v, input logic [3:0] n);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < n) r = r ^ v[i];
		end
		return r;
	endfunction

	// Parity bit value to send or expect
	function automatic logic par_bit(input casp_par_e p, input logic ones, input logic ms);
		return (p == CASP_PAR_ODD) ? ~ones : (p == CASP_PAR_EVEN) ? ones : ms;
	endfunction

	// Configuration decode
	assign dbits   = (q.ctrl[CASP_CTRL_DBITS_LSB +: 4] < 4'h5) ? 4'h5 :
		(q.ctrl[CASP_CTRL_DBITS_LSB +: 4] > 4'h9) ? 4'h9 : q.ctrl[CASP_CTRL_DBITS_LSB +: 4];
	assign par     = casp_par_e'(q.ctrl[CASP_CTRL_PAR_LSB +: 2]);
	assign os_max  = q.ctrl[CASP_CTRL_OS8_BIT] ? 4'h7 : 4'hF;
	assign rx_s    = q.rx_sy[1];
	assign cts_s   = q.cts_sy[1];
	assign tick_os = q.tick;
	assign last_os = tick_os && (q.tx_os == os_max);
	assign mid_os  = tick_os && (q.rx_os == {1'b0, os_max[3:1]});
	// Two of three around mid-bit, or the centre sample alone
	assign rx_bit  = q.ctrl[CASP_CTRL_VOTE_BIT] ?
		((q.vote[0] & q.vote[1]) | (q.vote[1] & rx_s) | (q.vote[0] & rx_s)) : rx_s;
	assign fifo_w  = '{brk: q.rx_zero & ~rx_bit & (q.rx_sh == '0), frame_err: ~rx_bit,
		par_err: (par != CASP_PAR_NONE) && (q.rx_par != par_bit(par, odd_ones(q.rx_sh, dbits), 1'b0))
			&& (par != CASP_PAR_MS), ninth: q.rx_par & (par == CASP_PAR_MS), data: q.rx_sh};
	// An accepted read of the data register pops the head character
	assign fifo_rd = s_axi_arvalid && s_axi_arready && ({s_axi_araddr[7:2], 2'b00} == CASP_RXDATA_OFS);
	// Status words
	assign rx_sts  = {q.mrk, q.adm, q.ovr, fifo_r.brk & ~fifo_empty, fifo_r.frame_err & ~fifo_empty,
		fifo_r.par_err & ~fifo_empty, ~fifo_empty};
	assign tx_sts  = {~q.th_v, q.th_v, ~q.th_v, q.tx_done};
	// Interrupt levels
	assign rx_irq_out = HAS_RX && |(rx_sts & q.irqen[6:0]);
	assign tx_irq_out = HAS_TX && |(tx_sts & q.irqen[11:8]);
	assign rts_n_out  = q.ctrl[CASP_CTRL_FLOW_BIT] & fifo_full;
	assign s_axi_awready = !q.aw_h && !q.bv;
	assign s_axi_wready  = !q.w_h && !q.bv;
	assign s_axi_arready = !q.rv;
	assign s_axi_bvalid  = q.bv;
	assign s_axi_bresp   = 2'b00;
	assign s_axi_rvalid  = q.rv;
	assign s_axi_rresp   = 2'b00;
	assign s_axi_rdata   = q.rdat;
	assign tx_out        = (q.tx_st == CASP_IDLE) ? 1'b1 : q.tx_sh[0] | (q.tx_st == CASP_STOP);
	assign tx_en_out     = (q.tx_st != CASP_IDLE);
	assign tx_crc_data_out = q.txc_d;
	assign tx_crc_clk_out  = q.txc_c;
	assign rx_crc_data_out = q.rxc_d;
	assign rx_crc_clk_out  = q.rxc_c;

	// Main next-state logic
	always_comb begin
		logic rd_take;
		rd_take = 1'b0;
		d = q;
		fifo_wr = 1'b0;
		d.rx_sy  = {q.rx_sy[0], rx_in};
		d.cts_sy = {q.cts_sy[0], cts_n_in};
		// Oversampling tick from the divider
		d.tick = 1'b0;
		d.pre  = q.pre + 16'h0001;
		if (q.pre >= q.div - 16'h0001) begin
			d.pre  = '0;
			d.tick = 1'b1;
		end
		d.txc_c = 1'b0;
		d.rxc_c = 1'b0;
		d.tx_done = q.tx_done;
		// Register writes
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_h = 1'b1;
			d.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_h = 1'b1;
			d.w_d = s_axi_wdata;
		end
		if (q.aw_h && q.w_h) begin
			d.aw_h = 1'b0;
			d.w_h  = 1'b0;
			d.bv   = 1'b1;
			unique case ({q.aw_a[7:2], 2'b00})
				CASP_CTRL_OFS: d.ctrl = q.w_d;
				CASP_IRQEN_OFS: d.irqen = q.w_d;
				CASP_ADDR_OFS: d.addr = q.w_d[15:0];
				CASP_DIV_OFS: d.div = (q.w_d[15:0] == '0) ? CASP_DIV_RST : q.w_d[15:0];
				CASP_TXDATA_OFS: begin
					if (!q.th_v) begin
						d.th_v = 1'b1;
						d.th_d = q.w_d[8:0];
						d.tx_done = 1'b0;
					end
				end
				CASP_STATUS_OFS: begin
					d.ovr = 1'b0;
					d.adm = 1'b0;
					d.mrk = 1'b0;
					d.tx_done = 1'b0;
				end
				default: ;
			endcase
		end
		if (q.bv && s_axi_bready) d.bv = 1'b0;
		// Register reads
		if (s_axi_arvalid && s_axi_arready) begin
			d.rv = 1'b1;
			unique case ({s_axi_araddr[7:2], 2'b00})
				CASP_CTRL_OFS: d.rdat = q.ctrl;
				CASP_STATUS_OFS: d.rdat = {16'h0000, 4'h0, tx_sts, 1'b0, rx_sts};
				CASP_RXDATA_OFS: begin
					d.rdat = {19'h00000, fifo_r.brk, fifo_r.frame_err, fifo_r.par_err, fifo_r.ninth,
						fifo_r.data & {9{~fifo_empty}}};
					rd_take = 1'b1;
				end
				CASP_IRQEN_OFS: d.rdat = q.irqen;
				CASP_ADDR_OFS: d.rdat = {16'h0000, q.addr};
				CASP_DIV_OFS: d.rdat = {16'h0000, q.div};
				default: d.rdat = '0;
			endcase
		end
		if (q.rv && s_axi_rready) d.rv = 1'b0;
		// Transmitter
		if (tick_os) d.tx_os = (q.tx_os == os_max) ? 4'h0 : q.tx_os + 4'h1;
		unique case (q.tx_st)
			CASP_IDLE: begin
				d.tx_os = '0;
				if (!HAS_TX || !q.ctrl[CASP_CTRL_TXON_BIT]) begin
					d.tx_st = CASP_IDLE;
				end else if (q.ctrl[CASP_CTRL_BREAK_BIT]) begin
					d.tx_st = CASP_BREAK;
					d.tx_sh = '0;
					d.brk_n = '0;
					d.tx_n  = '0;
				end else if (q.th_v && (!q.ctrl[CASP_CTRL_FLOW_BIT] || !cts_s)) begin
					d.tx_st = CASP_START;
					d.tx_sh = '0;
					d.tx_par = par_bit(par, odd_ones(q.th_d, dbits), q.ctrl[CASP_CTRL_MARK_BIT]);
					d.th_v = 1'b0;
					d.tx_n = '0;
				end
			end
			CASP_START: if (last_os) begin
				d.tx_st = CASP_DATA;
				d.tx_sh = q.th_d;
			end
			CASP_DATA: if (last_os) begin
				d.tx_sh = {1'b0, q.tx_sh[8:1]};
				d.tx_n  = q.tx_n + 4'h1;
				d.txc_d = q.tx_sh[0];
				d.txc_c = 1'b1;
				if (q.tx_n == dbits - 4'h1) begin
					d.tx_sh[0] = q.tx_par;
					d.tx_st = (par == CASP_PAR_NONE) ? CASP_STOP : CASP_PARITY;
					d.tx_n = '0;
				end
			end
			CASP_PARITY: if (last_os) begin
				d.tx_st = CASP_STOP;
				d.tx_n  = '0;
			end
			CASP_STOP: if (last_os) begin
				d.tx_n = q.tx_n + 4'h1;
				if (q.tx_n >= {3'b000, q.ctrl[CASP_CTRL_STOP2_BIT]}) begin // Safe if stop count shrinks mid-frame
					d.tx_st = CASP_IDLE;
					d.tx_done = 1'b1;
				end
			end
			CASP_BREAK: if (last_os) begin
				d.brk_n = q.brk_n + 5'h01;
				if (q.brk_n == CASP_BREAK_BITS - 5'h01) d.tx_st = CASP_STOP;
			end
			default: d.tx_st = CASP_IDLE;
		endcase
		// Receiver
		d.prev_rx = rx_s;
		if (tick_os) begin
			d.rx_os = (q.rx_os == os_max) ? 4'h0 : q.rx_os + 4'h1;
			d.vote  = {q.vote[1:0], rx_s};
		end
		unique case (q.rx_st)
			CASP_IDLE: begin
				d.rx_os = '0;
				if (HAS_RX && q.ctrl[CASP_CTRL_RXON_BIT] && q.prev_rx && !rx_s) d.rx_st = CASP_START;
			end
			CASP_START: if (mid_os) begin
				d.rx_st = rx_bit ? CASP_IDLE : CASP_DATA;
				d.rx_os = 4'h0 + {1'b0, os_max[3:1]} + 4'h1;
				d.rx_n = '0;
				d.rx_sh = '0;
				d.rx_zero = 1'b1;
			end
			CASP_DATA: if (mid_os) begin
				d.rx_sh[q.rx_n] = rx_bit;
				d.rx_n = q.rx_n + 4'h1;
				d.rx_zero = q.rx_zero & ~rx_bit;
				d.rxc_d = rx_bit;
				d.rxc_c = 1'b1;
				if (q.rx_n == dbits - 4'h1) d.rx_st = (par == CASP_PAR_NONE) ? CASP_STOP : CASP_PARITY;
			end
			CASP_PARITY: if (mid_os) begin
				d.rx_par = rx_bit;
				d.rx_zero = q.rx_zero & ~rx_bit;
				d.rx_st = CASP_STOP;
			end
			CASP_STOP: if (mid_os) begin
				d.rx_st = CASP_IDLE;
				// Address characters in nine-bit mode
				if (par == CASP_PAR_MS && q.rx_par) begin
					d.mrk = 1'b1;
					if (q.rx_sh[7:0] == q.addr[7:0] || q.rx_sh[7:0] == q.addr[15:8]) d.adm = 1'b1;
				end
				if (fifo_full) d.ovr = 1'b1;
				else fifo_wr = 1'b1;
				if (par != CASP_PAR_MS) d.rx_par = 1'b0;
			end
			default: d.rx_st = CASP_IDLE;
		endcase
		if (rd_take) d.rdat = d.rdat;
		// Synchronous reset returns both engines to idle
		if (srst_in) begin
			d.tx_st = CASP_IDLE;
			d.rx_st = CASP_IDLE;
			d.th_v  = 1'b0;
			d.txc_c = 1'b0;
			d.rxc_c = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q <= '0;
			q.rx_sy <= 2'b11;
			q.cts_sy <= 2'b11;
			q.prev_rx <= 1'b1;
			q.ctrl <= CASP_CTRL_RST;
			q.irqen <= CASP_IRQEN_RST;
			q.div <= CASP_DIV_RST;
			q.addr <= CASP_ADDR_RST;
			q.rx_st <= CASP_IDLE;
			q.tx_st <= CASP_IDLE;
		end else begin
			q <= d;
		end
	end

	// Receive FIFO; a read of the data register pops it
	casp_fifo u_rx_fifo (
		.clk_sys_in (clk_sys_in),
		.arst_n_in  (arst_n_in),
		.wr_in      (fifo_wr),
		.wdata_in   (fifo_w),
		.rd_in      (fifo_rd),
		.rdata_out  (fifo_r),
		.empty_out  (fifo_empty),
		.full_out   (fifo_full)
	);
endmodule

// File: casp_uart_sva.sv
// Checker for casp_uart: bus handshake timing and serial line framing.
// Assumes it is bound onto casp_uart and sees only that module's ports.
`timescale 1ns/1ps
module casp_uart_sva (
	// Clock and resets
	input wire logic        clk_sys_in,
	input wire logic        arst_n_in,
	input wire logic        srst_in,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	// Serial side
	input wire logic        tx_out,
	input wire logic        tx_en_out,
	input wire logic        tx_crc_clk_out,
	input wire logic        rx_crc_clk_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	// Both write channels taken in one cycle
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Start edge followed by at least one short bit time low
	sequence start_bit;
		$fell(tx_out) ##0 !tx_out[*8];
	endsequence
	// Bus answers and holds
	a_write_resp:  assert property (wr_both |=> ##1 s_axi_bvalid) else $error("write response not on time");
	a_bresp_hold:  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_bresp_okay:  assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00) else $error("bad write response");
	a_read_resp:   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
	a_rdata_hold:  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_read_block:  assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_rresp_okay:  assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00) else $error("bad read response");
	// Line framing and transmit enable
	a_idle_high:   assert property (!tx_en_out |-> tx_out) else $error("line low while not enabled");
	a_start_len:   assert property (disable iff (!arst_n_in || srst_in) $fell(tx_out) |-> start_bit)
		else $error("start bit too short");
	a_en_late:     assert property ($fell(tx_en_out) && !$past(srst_in) |-> tx_out && $past(tx_out, 7))
		else $error("enable dropped before stop ended");
	a_abandon_char: assert property (srst_in |=> ##1 tx_out && !tx_en_out) else $error("reset left engine busy");
	// CRC feed clocks pulse for one cycle, the transmit one only inside a frame
	a_txcrc_pulse: assert property (tx_crc_clk_out |-> tx_en_out ##1 !tx_crc_clk_out) else $error("tx crc clock");
	a_rxcrc_pulse: assert property (rx_crc_clk_out |=> !rx_crc_clk_out[*4]) else $error("rx crc clock");
endmodule

bind casp_uart casp_uart_sva chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .srst_in(srst_in),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
	.tx_out(tx_out), .tx_en_out(tx_en_out), .tx_crc_clk_out(tx_crc_clk_out), .rx_crc_clk_out(rx_crc_clk_out));

// File: tb.sv
// Self-checking bench for casp_uart: registers over AXI4-Lite, serial traffic through casp_peer.
// Assumes DIV keeps its reset value, so a bit lasts 16 clocks (8 in 8x mode).
`timescale 1ns/1ps
module tb;
	import casp_pkg::*;
	// Design signals
	logic        clk_sys_in, arst_n_in, srst_in, rx_in, cts_n_in;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        tx_out, rts_n_out, tx_en_out, tx_irq_out, rx_irq_out;
	logic        tx_crc_data_out, tx_crc_clk_out, rx_crc_data_out, rx_crc_clk_out;
	logic [9:0]  f;
	bit          ok;
	logic [15:0] crc_tx, crc_rx;
	int          err_count, check_count, nd;
	// Frame table: control, data, bits after start, stops, bit time, expected bits
	logic [31:0] cfg_t [5] = '{32'h0000_3008, 32'h0000_3067, 32'h0000_3015, 32'h0000_3088, 32'h0000_7038};
	logic [9:0]  dat_t [5] = '{10'h0A5, 10'h031, 10'h013, 10'h05C, 10'h03C};
	logic [9:0]  exp_t [5] = '{10'h0A5, 10'h0B1, 10'h013, 10'h05C, 10'h13C};
	int          nb_t [5] = '{8, 8, 6, 8, 9};
	int          ns_t [5] = '{1, 2, 1, 1, 1};
	int          bl_t [5] = '{16, 16, 16, 8, 16};

	casp_uart uut (.*);
	casp_peer peer (.clk_sys_in(clk_sys_in), .tx_in(tx_out), .rx_out(rx_in), .cts_n_out(cts_n_in));

	// CRC feed capture, newest bit enters at the top
	always @(posedge clk_sys_in) begin
		if (tx_crc_clk_out) crc_tx <= {tx_crc_data_out, crc_tx[15:1]};
		if (rx_crc_clk_out) crc_rx <= {rx_crc_data_out, crc_rx[15:1]};
	end

	// 200 MHz clock
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	// Bus read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
	// Counts and verdict
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (30000) @(posedge clk_sys_in);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		results();
	end
	// Test sequence
	initial begin
		arst_n_in = 1'b0;
		srst_in = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		axi_rd(CASP_CTRL_OFS, d);
		check(d, CASP_CTRL_RST);
		axi_rd(CASP_DIV_OFS, d);
		check(d, {16'h0000, CASP_DIV_RST});
		axi_rd(8'h1C, d);
		check(d, 32'h0000_0000);
		$display("test defaults done");
		for (int i = 0; i < 5; i++) begin
			peer.bit_len = bl_t[i];
			axi_wr(CASP_CTRL_OFS, cfg_t[i]);
			fork
				peer.get(nb_t[i], ns_t[i], f, ok);
				axi_wr(CASP_TXDATA_OFS, {22'h0, dat_t[i]});
			join
			check({22'h0, f}, {22'h0, exp_t[i]});
			check({31'h0, ok}, 32'h1);
			nd = cfg_t[i][3:0];
			check(32'(crc_tx >> (16 - nd)), 32'(dat_t[i] & ((10'h1 << nd) - 1)));
		end
		// Completion interrupt follows the done flag and its clear
		repeat (16) @(posedge clk_sys_in);
		axi_wr(CASP_IRQEN_OFS, 32'h0000_0100);
		check({31'h0, tx_irq_out}, 32'h1);
		axi_wr(CASP_STATUS_OFS, 32'h0000_0000);
		check({31'h0, tx_irq_out}, 32'h0);
		$display("test transmit frames done");
		peer.bit_len = 16;
		axi_wr(CASP_CTRL_OFS, 32'h0000_3108);
		axi_wr(CASP_IRQEN_OFS, 32'h0000_0001);
		peer.send(10'h03C, 8, 1'b1);
		repeat (4) @(posedge clk_sys_in);
		check({31'h0, rx_irq_out}, 32'h1);
		axi_rd(CASP_RXDATA_OFS, d);
		check({24'h0, d[7:0]}, 32'h3C);
		check({24'h0, crc_rx[15:8]}, 32'h3C);
		repeat (4) @(posedge clk_sys_in);
		check({31'h0, rx_irq_out}, 32'h0);
		// Even parity expects a one here, peer sends zero
		axi_wr(CASP_CTRL_OFS, 32'h0000_3028);
		peer.send(10'h001, 9, 1'b1);
		axi_rd(CASP_STATUS_OFS, d);
		check({31'h0, d[1]}, 32'h1);
		axi_rd(CASP_RXDATA_OFS, d);
		axi_wr(CASP_CTRL_OFS, 32'h0000_3008);
		peer.send(10'h000, 8, 1'b0);
		axi_rd(CASP_STATUS_OFS, d);
		check({31'h0, d[2]}, 32'h1);
		check({31'h0, d[3]}, 32'h1);
		axi_rd(CASP_RXDATA_OFS, d);
		// Nine-bit address character matching the first station address
		axi_wr(CASP_ADDR_OFS, 32'h0000_0012);
		axi_wr(CASP_CTRL_OFS, 32'h0000_3038);
		peer.send(10'h112, 9, 1'b1);
		axi_rd(CASP_STATUS_OFS, d);
		check({30'h0, d[6:5]}, 32'h3);
		axi_rd(CASP_RXDATA_OFS, d);
		check({22'h0, d[9:0]}, 32'h212);
		$display("test receive done");
		// Flow control on, five characters into a four-deep FIFO
		axi_wr(CASP_CTRL_OFS, 32'h0000_3208);
		for (int i = 0; i < 5; i++) peer.send(10'(64 + i), 8, 1'b1);
		check({31'h0, rts_n_out}, 32'h1);
		axi_rd(CASP_STATUS_OFS, d);
		check({31'h0, d[4]}, 32'h1);
		axi_rd(CASP_RXDATA_OFS, d);
		check({24'h0, d[7:0]}, 32'h40);
		repeat (4) @(posedge clk_sys_in);
		check({31'h0, rts_n_out}, 32'h0);
		// Transmission held back until clear-to-send goes low
		peer.set_cts(1'b1);
		axi_wr(CASP_TXDATA_OFS, 32'h0000_0066);
		repeat (64) @(posedge clk_sys_in);
		check({31'h0, tx_out}, 32'h1);
		fork
			peer.get(8, 1, f, ok);
			peer.set_cts(1'b0);
		join
		check({22'h0, f}, 32'h066);
		$display("test flow control done");
		// Synchronous reset in mid-character
		axi_wr(CASP_TXDATA_OFS, 32'h0000_0000);
		repeat (40) @(posedge clk_sys_in);
		srst_in <= 1'b1;
		@(posedge clk_sys_in);
		srst_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		check({30'h0, tx_out, tx_en_out}, 32'h2);
		repeat (100) @(posedge clk_sys_in);
		check({31'h0, tx_out}, 32'h1);
		// Break holds the line low with enable high
		axi_wr(CASP_CTRL_OFS, 32'h0000_3408);
		repeat (48) @(posedge clk_sys_in);
		check({30'h0, tx_out, tx_en_out}, 32'h1);
		axi_wr(CASP_CTRL_OFS, 32'h0000_3008);
		repeat (300) @(posedge clk_sys_in);
		$display("test reset and break done");
		results();
	end
endmodule
